// ### logic/pwr_ctrl_defs.svh
// constants for the dual radio power enable control block
`ifndef PWR_CTRL_DEFS_SVH
`define PWR_CTRL_DEFS_SVH

// ----------------------------------------
// reference frequency, in kHz
// ----------------------------------------
`define REF_FREQ_DEFAULT_KHZ 20'h09218
`define REF_FREQ_W 20

// ----------------------------------------
// timing
// ----------------------------------------
`define CORE_CLK_PERIOD_NS 40
`define SYNC_STAGES 2

`endif

// ### logic/pwr_ctrl_pkg.sv
// types for the dual radio power enable control block
package pwr_ctrl_pkg;
	typedef enum logic [1:0] {
		SEC_OFF   = 2'b00,
		SEC_WAIT  = 2'b01,
		SEC_RUN   = 2'b10
	} sec_state_t;
endpackage

// ### logic/enable_sync.sv
// two-stage synchroniser for one enable pin
`timescale 1ns/1ps
`default_nettype none
module enable_sync (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;

	always_comb begin
		meta_nxt = async_i;
		sync_nxt = meta_r;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_o = sync_r;
endmodule
`default_nettype wire

// ### logic/dual_radio_power_enable_control.sv
// power enable, section reset and shutdown control for the dual radio device
`timescale 1ns/1ps
`default_nettype none
`include "pwr_ctrl_defs.svh"
module dual_radio_power_enable_control (
	input  wire logic                   core_clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   wlan_power_enable_pin_i,
	input  wire logic                   bt_power_enable_pin_i,
	input  wire logic                   regulators_ready_i,
	input  wire logic                   pulldown_disable_i,
	input  wire logic                   ref_freq_wr_i,
	input  wire logic [`REF_FREQ_W-1:0] ref_freq_khz_i,
	input  wire logic                   io_out_en_req_i,
	input  wire logic                   io_in_en_req_i,
	output logic                        regulators_enable_o,
	output logic                        wlan_reset_o,
	output logic                        bt_reset_o,
	output logic                        wlan_pulldown_en_o,
	output logic                        bt_pulldown_en_o,
	output logic                        shutdown_o,
	output logic                        io_out_en_o,
	output logic                        io_in_en_o,
	output logic [`REF_FREQ_W-1:0]      ref_freq_khz_o
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic wl_en;
	logic bt_en;

	enable_sync u_wl_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    (wlan_power_enable_pin_i),
		.sync_o     (wl_en)
	);
	enable_sync u_bt_sync (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.async_i    (bt_power_enable_pin_i),
		.sync_o     (bt_en)
	);

	// ----------------------------------------
	// state
	// ----------------------------------------
	pwr_ctrl_pkg::sec_state_t wl_st_r;
	pwr_ctrl_pkg::sec_state_t wl_st_nxt;
	pwr_ctrl_pkg::sec_state_t bt_st_r;
	pwr_ctrl_pkg::sec_state_t bt_st_nxt;
	logic                     reg_en_r;
	logic                     reg_en_nxt;
	logic                     wl_rst_r;
	logic                     wl_rst_nxt;
	logic                     bt_rst_r;
	logic                     bt_rst_nxt;
	logic                     pd_r;
	logic                     pd_nxt;
	logic                     shut_r;
	logic                     shut_nxt;
	logic                     oen_r;
	logic                     oen_nxt;
	logic                     ien_r;
	logic                     ien_nxt;
	logic [`REF_FREQ_W-1:0]   ref_r;
	logic [`REF_FREQ_W-1:0]   ref_nxt;

	always_comb begin
		reg_en_nxt = wl_en | bt_en;
		shut_nxt   = ~(wl_en | bt_en);
		oen_nxt    = (wl_en | bt_en) & io_out_en_req_i;
		ien_nxt    = (wl_en | bt_en) & io_in_en_req_i;
		// pull-downs on from reset until disabled
		pd_nxt     = pd_r & ~pulldown_disable_i;
		// no crystal versus oscillator selection exists
		ref_nxt    = ref_freq_wr_i ? ref_freq_khz_i : ref_r;
		if (shut_r) begin
			pd_nxt  = 1'b1;
			ref_nxt = `REF_FREQ_DEFAULT_KHZ;
		end
		wl_st_nxt = wl_st_r;
		unique case (wl_st_r)
			pwr_ctrl_pkg::SEC_OFF: begin
				if (wl_en) begin
					wl_st_nxt = pwr_ctrl_pkg::SEC_WAIT;
				end
			end
			pwr_ctrl_pkg::SEC_WAIT: begin
				if (!wl_en) begin
					wl_st_nxt = pwr_ctrl_pkg::SEC_OFF;
				end else if (regulators_ready_i && reg_en_r) begin
					wl_st_nxt = pwr_ctrl_pkg::SEC_RUN;
				end
			end
			pwr_ctrl_pkg::SEC_RUN: begin
				if (!wl_en) begin
					wl_st_nxt = pwr_ctrl_pkg::SEC_OFF;
				end
			end
			default: wl_st_nxt = pwr_ctrl_pkg::SEC_OFF;
		endcase
		bt_st_nxt = bt_st_r;
		unique case (bt_st_r)
			pwr_ctrl_pkg::SEC_OFF: begin
				if (bt_en) begin
					bt_st_nxt = pwr_ctrl_pkg::SEC_WAIT;
				end
			end
			pwr_ctrl_pkg::SEC_WAIT: begin
				if (!bt_en) begin
					bt_st_nxt = pwr_ctrl_pkg::SEC_OFF;
				end else if (regulators_ready_i && reg_en_r) begin
					bt_st_nxt = pwr_ctrl_pkg::SEC_RUN;
				end
			end
			pwr_ctrl_pkg::SEC_RUN: begin
				if (!bt_en) begin
					bt_st_nxt = pwr_ctrl_pkg::SEC_OFF;
				end
			end
			default: bt_st_nxt = pwr_ctrl_pkg::SEC_OFF;
		endcase
		wl_rst_nxt = (wl_st_nxt != pwr_ctrl_pkg::SEC_RUN);
		bt_rst_nxt = (bt_st_nxt != pwr_ctrl_pkg::SEC_RUN);
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wl_st_r  <= pwr_ctrl_pkg::SEC_OFF;
			bt_st_r  <= pwr_ctrl_pkg::SEC_OFF;
			reg_en_r <= 1'b0;
			wl_rst_r <= 1'b1;
			bt_rst_r <= 1'b1;
			pd_r     <= 1'b1;
			shut_r   <= 1'b1;
			oen_r    <= 1'b0;
			ien_r    <= 1'b0;
			ref_r    <= `REF_FREQ_DEFAULT_KHZ;
		end else begin
			wl_st_r  <= wl_st_nxt;
			bt_st_r  <= bt_st_nxt;
			reg_en_r <= reg_en_nxt;
			wl_rst_r <= wl_rst_nxt;
			bt_rst_r <= bt_rst_nxt;
			pd_r     <= pd_nxt;
			shut_r   <= shut_nxt;
			oen_r    <= oen_nxt;
			ien_r    <= ien_nxt;
			ref_r    <= ref_nxt;
		end
	end

	assign regulators_enable_o = reg_en_r;
	assign wlan_reset_o        = wl_rst_r;
	assign bt_reset_o          = bt_rst_r;
	assign wlan_pulldown_en_o  = pd_r;
	assign bt_pulldown_en_o    = pd_r;
	assign shutdown_o          = shut_r;
	assign io_out_en_o         = oen_r;
	assign io_in_en_o          = ien_r;
	assign ref_freq_khz_o      = ref_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence both_low_s;
		!wl_en && !bt_en;
	endsequence

	reg_or_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wl_en || bt_en) |=> reg_en_r)
		else $error("regulators not on with an enable high");
	reg_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		both_low_s |=> !reg_en_r && shut_r)
		else $error("regulators not off with both enables low");
	wl_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!wl_en |=> wl_rst_r)
		else $error("wlan reset released with pin low");
	wl_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wl_st_r == pwr_ctrl_pkg::SEC_WAIT && wl_en && regulators_ready_i && reg_en_r)
		|=> !wl_rst_r && reg_en_r)
		else $error("wlan reset not released");
	bt_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!bt_en |=> bt_rst_r)
		else $error("bt reset released with pin low");
	ready_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(wl_rst_r) |-> $past(regulators_ready_i))
		else $error("wlan released before regulators ready");
	pd_keep_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(pd_r && !pulldown_disable_i && !shut_r) |=> pd_r)
		else $error("pull-down dropped without request");
	shut_io_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		both_low_s |=> !io_out_en_o && !io_in_en_o)
		else $error("io active in shutdown");
	shut_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		shut_r |=> ref_r == `REF_FREQ_DEFAULT_KHZ && pd_r)
		else $error("state kept across shutdown");
	ref_load_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(ref_freq_wr_i && !shut_r) |=> ref_r == $past(ref_freq_khz_i))
		else $error("reference frequency not loaded");

	sequence bt_ready_s;
		bt_st_r == pwr_ctrl_pkg::SEC_WAIT && bt_en && regulators_ready_i && reg_en_r;
	endsequence

	bt_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		bt_ready_s |=> !bt_rst_r && reg_en_r)
		else $error("bt reset not released");
	bt_gate_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		$fell(bt_rst_r) |-> $past(regulators_ready_i))
		else $error("bt released before regulators ready");
	io_req_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(wl_en || bt_en) |=> io_out_en_o == $past(io_out_en_req_i) && io_in_en_o == $past(io_in_en_req_i))
		else $error("io enables do not follow requests");
endmodule
`default_nettype wire

// ### tb/host_pins_model.sv
// host side model: enable pins and regulator ready report
`timescale 1ns/1ps
`default_nettype none
module host_pins_model (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic wlan_cmd_i,
	input  wire logic bt_cmd_i,
	input  wire logic slow_i,
	input  wire logic regulators_enable_i,
	output logic      wlan_pin_o,
	output logic      bt_pin_o,
	output logic      ready_o
);
	logic [2:0] cnt_r;
	assign wlan_pin_o = wlan_cmd_i;
	assign bt_pin_o   = bt_cmd_i;
	// ---------------------------------
	// ready report, prompt or slow
	// ---------------------------------
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r   <= 3'h0;
			ready_o <= 1'b0;
		end else if (!regulators_enable_i) begin
			cnt_r   <= 3'h0;
			ready_o <= 1'b0;
		end else begin
			if (cnt_r != 3'h7) begin
				cnt_r <= cnt_r + 3'h1;
			end
			ready_o <= slow_i ? (cnt_r >= 3'h3) : 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### tb/dual_radio_power_enable_control_tb.sv
// self-checking bench for the power enable control block
`timescale 1ns/1ps
`default_nettype none
`include "pwr_ctrl_defs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module dual_radio_power_enable_control_tb;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wcmd = 1'b0, bcmd = 1'b0, slow = 1'b0, pd_dis = 1'b0, wr = 1'b0;
	logic oreq = 1'b1, ireq = 1'b1;
	logic [`REF_FREQ_W-1:0] freq = 20'h00000;
	logic wpin, bpin, rdy, reg_en, wrst, brst, wpd, bpd, sd, oen, ien;
	logic [`REF_FREQ_W-1:0] ref_o;
	int miscompares = 0, checked = 0, cycles = 0;
	always #20 core_clk_i = ~core_clk_i;
	host_pins_model host (.core_clk_i(core_clk_i), .rst_i(rst_i), .wlan_cmd_i(wcmd),
		.bt_cmd_i(bcmd), .slow_i(slow), .regulators_enable_i(reg_en),
		.wlan_pin_o(wpin), .bt_pin_o(bpin), .ready_o(rdy));
	dual_radio_power_enable_control dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.wlan_power_enable_pin_i(wpin), .bt_power_enable_pin_i(bpin),
		.regulators_ready_i(rdy), .pulldown_disable_i(pd_dis), .ref_freq_wr_i(wr),
		.ref_freq_khz_i(freq), .io_out_en_req_i(oreq), .io_in_en_req_i(ireq),
		.regulators_enable_o(reg_en), .wlan_reset_o(wrst), .bt_reset_o(brst),
		.wlan_pulldown_en_o(wpd), .bt_pulldown_en_o(bpd), .shutdown_o(sd),
		.io_out_en_o(oen), .io_in_en_o(ien), .ref_freq_khz_o(ref_o));
	task automatic set_pins(input logic w, input logic b);
		@(posedge core_clk_i);
		wcmd <= w;
		bcmd <= b;
		repeat (10) @(posedge core_clk_i);
		#1;
	endtask
	task automatic t_reset();
		`CHK({reg_en, wrst, brst, wpd, bpd, sd, oen, ien}, 8'h7C)
		`CHK(ref_o, `REF_FREQ_DEFAULT_KHZ)
	endtask
	task automatic t_wlan();
		set_pins(1'b1, 1'b0);
		`CHK({reg_en, wrst, brst, sd}, 4'hA)
		`CHK({oen, ien}, 2'h3)
		@(posedge core_clk_i);
		oreq <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		#1;
		`CHK({oen, ien}, 2'h1)
		@(posedge core_clk_i);
		oreq <= 1'b1;
	endtask
	task automatic t_bt();
		set_pins(1'b0, 1'b1);
		`CHK({reg_en, wrst, brst}, 3'h6)
		set_pins(1'b1, 1'b1);
		`CHK({reg_en, wrst, brst}, 3'h4)
	endtask
	task automatic t_off();
		set_pins(1'b0, 1'b0);
		`CHK({reg_en, wrst, brst, sd}, 4'h7)
		`CHK({oen, ien}, 2'h0)
	endtask
	task automatic t_slow();
		@(posedge core_clk_i);
		slow <= 1'b1;
		wcmd <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		#1;
		`CHK({reg_en, wrst}, 2'h3)
		repeat (8) @(posedge core_clk_i);
		#1;
		`CHK({reg_en, wrst}, 2'h2)
		slow <= 1'b0;
	endtask
	task automatic t_keep();
		@(posedge core_clk_i);
		wr <= 1'b1;
		freq <= 20'h06590;
		pd_dis <= 1'b1;
		@(posedge core_clk_i);
		wr <= 1'b0;
		pd_dis <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1;
		`CHK(ref_o, 20'h06590)
		`CHK({wpd, bpd}, 2'h0)
		set_pins(1'b0, 1'b0);
		set_pins(1'b1, 1'b0);
		`CHK(ref_o, `REF_FREQ_DEFAULT_KHZ)
		`CHK({wpd, bpd}, 2'h3)
	endtask
	task automatic summarize();
		if (miscompares == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		#1;
		t_reset();
		t_wlan();
		t_bt();
		t_off();
		t_slow();
		t_keep();
		t_off();
		summarize();
	end
endmodule
`default_nettype wire
